// ### hw/srs_top.v
/*
  special register space of an 8-bit core: decode of the register map,
  program status word with hardware parity, working register bank base.
  assumes the core drives flag updates and reaches registers over a plain
  address/strobe port with read data one cycle after the read strobe.
*/
// How it works
// - unmapped reads return undefined data, here zero
// - third timer registers exist only if enabled
// - aux register: mul/div operand, else scratch
// - bit 6 half carry, updated by hardware
// - bit 5 user flag, software only
// - bits 4:3 pick bank 00h,08h,10h,18h
// - bit 0 parity of accumulator, every cycle
`timescale 1ns/10ps
`include "srs_consts.vh"
module srs_top #(
   parameter HAS_TIMER2 = 1
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       clk_en,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output wire [7:0] rdata,
   input  wire       cy_we,
   input  wire       cy_in,
   input  wire       ac_we,
   input  wire       ac_in,
   input  wire       ov_we,
   input  wire       ov_in,
   input  wire       acc_we,
   input  wire [7:0] acc_in,
   input  wire       aux_we,
   input  wire [7:0] aux_in,
   output wire [7:0] acc_out,
   output wire [7:0] aux_out,
   output wire [7:0] status_out,
   output wire [4:0] bank_base,
   output wire [7:0] port0_out,
   output wire [7:0] port1_out,
   output wire [7:0] port2_out,
   output wire [7:0] port3_out
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   localparam NREG = `SRS_NUM_REGS;
   localparam AW   = 5;
   localparam [AW-1:0] IDX_ACC   = 5'd24;
   localparam [AW-1:0] IDX_AUX   = 5'd25;
   localparam [AW-1:0] IDX_PORT0 = 5'd0;
   localparam [AW-1:0] IDX_PORT1 = 5'd11;
   localparam [AW-1:0] IDX_PORT2 = 5'd14;
   localparam [AW-1:0] IDX_PORT3 = 5'd16;

   reg  [AW-1:0] idx;
   reg           hit;
   reg           is_t2;

   always @*
   begin
      idx   = 5'd0;
      hit   = 1'b1;
      is_t2 = 1'b0;
      case (addr)
         `SRS_ADDR_PORT0:      idx = 5'd0;
         `SRS_ADDR_STACK:      idx = 5'd1;
         `SRS_ADDR_DPTR_LO:    idx = 5'd2;
         `SRS_ADDR_DPTR_HI:    idx = 5'd3;
         `SRS_ADDR_POWER:      idx = 5'd4;
         `SRS_ADDR_TIMER_CTL:  idx = 5'd5;
         `SRS_ADDR_TIMER_MODE: idx = 5'd6;
         `SRS_ADDR_T0_LO:      idx = 5'd7;
         `SRS_ADDR_T1_LO:      idx = 5'd8;
         `SRS_ADDR_T0_HI:      idx = 5'd9;
         `SRS_ADDR_T1_HI:      idx = 5'd10;
         `SRS_ADDR_PORT1:      idx = 5'd11;
         `SRS_ADDR_SER_CTL:    idx = 5'd12;
         `SRS_ADDR_SER_BUF:    idx = 5'd13;
         `SRS_ADDR_PORT2:      idx = 5'd14;
         `SRS_ADDR_INT_EN:     idx = 5'd15;
         `SRS_ADDR_PORT3:      idx = 5'd16;
         `SRS_ADDR_INT_PRIO:   idx = 5'd17;
         `SRS_ADDR_T2_CTL:
         begin
            idx   = 5'd18;
            is_t2 = 1'b1;
         end
         `SRS_ADDR_T2_CAP_LO:
         begin
            idx   = 5'd19;
            is_t2 = 1'b1;
         end
         `SRS_ADDR_T2_CAP_HI:
         begin
            idx   = 5'd20;
            is_t2 = 1'b1;
         end
         `SRS_ADDR_T2_LO:
         begin
            idx   = 5'd21;
            is_t2 = 1'b1;
         end
         `SRS_ADDR_T2_HI:
         begin
            idx   = 5'd22;
            is_t2 = 1'b1;
         end
         `SRS_ADDR_STATUS:     idx = 5'd23;
         `SRS_ADDR_ACC:        idx = IDX_ACC;
         `SRS_ADDR_AUX:        idx = IDX_AUX;
         default:              hit = 1'b0;
      endcase
      // third timer addresses vanish on variants without it
      if (is_t2 && (HAS_TIMER2 == 0))
         hit = 1'b0;
   end

   wire is_status = hit && (idx == 5'd23);
   wire is_core   = hit && ((idx == IDX_ACC) || (idx == IDX_AUX));

   // ----------------------------------------
   // register array write arbitration
   // ----------------------------------------
   // the array port serves bus writes only: acc and aux have flops of their
   // own, so a core update never steals the port from a bus write elsewhere;
   // writes to reserved addresses are simply dropped
   reg           arr_we;
   reg [AW-1:0]  arr_idx;
   reg [7:0]     arr_data;

   always @*
   begin
      arr_we   = 1'b0;
      arr_idx  = idx;
      arr_data = wdata;
      if (wr_stb && hit && !is_status && !is_core)
         arr_we = 1'b1;
   end

   // reset values per entry: ports high, stack pointer at its start value
   wire [NREG*8-1:0] rst_vals;
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1)
      begin : g_rst
         assign rst_vals[g*8 +: 8] =
            (g == 1) ? `SRS_RST_STACK :
            ((g == 0) || (g == 11) || (g == 14) || (g == 16)) ? `SRS_RST_PORT :
            `SRS_RST_BYTE;
      end
   endgenerate

   wire [NREG*8-1:0] all_q;
   wire [7:0]        arr_rd;

   srs_regfile #(
      .DEPTH (NREG),
      .AW    (AW),
      .WIDTH (8)
   ) u_regs (
      .clk        (clk),
      .rst_n      (rst_n),
      .clk_en     (clk_en),
      .wr_en      (arr_we),
      .wr_idx     (arr_idx),
      .wr_data    (arr_data),
      .rd_idx     (idx),
      .rst_vals   (rst_vals),
      .all_q      (all_q),
      .rd_data_ff (arr_rd)
   );


   // ----------------------------------------
   // accumulator and aux register
   // ----------------------------------------
   // a mul/div result lands in both in one cycle, hence two flops; a core
   // write wins over a bus write to the same register. the array entries
   // behind these two addresses stay at reset and are never read.
   reg  [7:0] acc_ff;
   reg  [7:0] aux_ff;
   wire       bus_acc = wr_stb && hit && (idx == IDX_ACC);
   wire       bus_aux = wr_stb && hit && (idx == IDX_AUX);
   wire [7:0] nxt_acc = acc_we ? acc_in : (bus_acc ? wdata : acc_ff);
   wire [7:0] nxt_aux = aux_we ? aux_in : (bus_aux ? wdata : aux_ff);

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         acc_ff <= `SRS_RST_BYTE;
         aux_ff <= `SRS_RST_BYTE;
      end
      else if (clk_en)
      begin
         acc_ff <= nxt_acc;
         aux_ff <= nxt_aux;
      end
   end

   assign acc_out   = acc_ff;
   assign aux_out   = aux_ff;
   assign port0_out = all_q[IDX_PORT0*8 +: 8];
   assign port1_out = all_q[IDX_PORT1*8 +: 8];
   assign port2_out = all_q[IDX_PORT2*8 +: 8];
   assign port3_out = all_q[IDX_PORT3*8 +: 8];

   // ----------------------------------------
   // program status word
   // ----------------------------------------
   reg        carry_out_flag_ff;
   reg        bcd_half_carry_ff;
   reg        user_flag_zero_ff;
   reg  [1:0] bank_sel_ff;
   reg        signed_range_exceeded_ff;
   reg        parity_ff;

   wire psw_wr = wr_stb && is_status;

   // parity follows the value the accumulator takes this cycle, so it is
   // never a cycle stale after an acc write
   wire       nxt_parity = ^nxt_acc;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         carry_out_flag_ff        <= 1'b0;
         bcd_half_carry_ff        <= 1'b0;
         user_flag_zero_ff        <= 1'b0;
         bank_sel_ff              <= 2'b00;
         signed_range_exceeded_ff <= 1'b0;
         parity_ff                <= 1'b0;
      end
      else if (clk_en)
      begin
         // hardware flag updates win over a software write in the same cycle
         if (cy_we)
            carry_out_flag_ff <= cy_in;
         else if (psw_wr)
            carry_out_flag_ff <= wdata[`SRS_PSW_CY];
         if (ac_we)
            bcd_half_carry_ff <= ac_in;
         else if (psw_wr)
            bcd_half_carry_ff <= wdata[`SRS_PSW_AC];
         if (ov_we)
            signed_range_exceeded_ff <= ov_in;
         else if (psw_wr)
            signed_range_exceeded_ff <= wdata[`SRS_PSW_OV];
         if (psw_wr)
         begin
            user_flag_zero_ff <= wdata[`SRS_PSW_F0];
            bank_sel_ff       <= {wdata[`SRS_PSW_BANK_HI], wdata[`SRS_PSW_BANK_LO]};
         end
         parity_ff <= nxt_parity;
      end
   end

   // reserved bit 1 reads zero; parity bit ignores writes
   assign status_out = {carry_out_flag_ff, bcd_half_carry_ff, user_flag_zero_ff,
                        bank_sel_ff, signed_range_exceeded_ff, 1'b0, parity_ff};

   // bank n starts at n*8 in internal data memory
   assign bank_base = {bank_sel_ff, 3'b000};

   // ----------------------------------------
   // read path
   // ----------------------------------------
   reg       rd_hit_ff;
   reg       rd_status_ff;
   reg       rd_valid_ff;
   reg       rd_core_sel_ff;
   reg [7:0] rd_core_ff;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_hit_ff    <= 1'b0;
         rd_status_ff <= 1'b0;
         rd_valid_ff  <= 1'b0;
         rd_core_sel_ff <= 1'b0;
         rd_core_ff     <= 8'h00;
      end
      else if (clk_en)
      begin
         rd_hit_ff    <= hit;
         rd_status_ff <= is_status;
         rd_valid_ff  <= rd_stb;
         rd_core_sel_ff <= is_core;
         rd_core_ff     <= (idx == IDX_AUX) ? aux_ff : acc_ff;
      end
   end

   // status is sampled live one cycle after the strobe; flags written in the
   // strobe cycle are already visible
   assign rdata = !rd_valid_ff  ? 8'h00 :
                  !rd_hit_ff    ? `SRS_UNMAPPED_READ :
                  rd_status_ff  ? status_out :
                  rd_core_sel_ff ? rd_core_ff : arr_rd;

endmodule

// ### hw/srs_consts.vh
/*
  constants for the special register space block: byte addresses of the
  register map, status word field positions, bank address stride.
  assumes inclusion by bare name from the design files.
*/
`ifndef SRS_CONSTS_VH
`define SRS_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SRS_ADDR_PORT0        8'h80
`define SRS_ADDR_STACK        8'h81
`define SRS_ADDR_DPTR_LO      8'h82
`define SRS_ADDR_DPTR_HI      8'h83
`define SRS_ADDR_POWER        8'h87
`define SRS_ADDR_TIMER_CTL    8'h88
`define SRS_ADDR_TIMER_MODE   8'h89
`define SRS_ADDR_T0_LO        8'h8A
`define SRS_ADDR_T1_LO        8'h8B
`define SRS_ADDR_T0_HI        8'h8C
`define SRS_ADDR_T1_HI        8'h8D
`define SRS_ADDR_PORT1        8'h90
`define SRS_ADDR_SER_CTL      8'h98
`define SRS_ADDR_SER_BUF      8'h99
`define SRS_ADDR_PORT2        8'hA0
`define SRS_ADDR_INT_EN       8'hA8
`define SRS_ADDR_PORT3        8'hB0
`define SRS_ADDR_INT_PRIO     8'hB8
`define SRS_ADDR_T2_CTL       8'hC8
`define SRS_ADDR_T2_CAP_LO    8'hCA
`define SRS_ADDR_T2_CAP_HI    8'hCB
`define SRS_ADDR_T2_LO        8'hCC
`define SRS_ADDR_T2_HI        8'hCD
`define SRS_ADDR_STATUS       8'hD0
`define SRS_ADDR_ACC          8'hE0
`define SRS_ADDR_AUX          8'hF0

// ----------------------------------------
// status word fields
// ----------------------------------------
`define SRS_PSW_CY            7
`define SRS_PSW_AC            6
`define SRS_PSW_F0            5
`define SRS_PSW_BANK_HI       4
`define SRS_PSW_BANK_LO       3
`define SRS_PSW_OV            2
`define SRS_PSW_RSVD          1
`define SRS_PSW_PAR           0

// ----------------------------------------
// reset values and misc
// ----------------------------------------
`define SRS_RST_BYTE          8'h00
`define SRS_RST_STACK         8'h07
`define SRS_RST_PORT          8'hFF
`define SRS_UNMAPPED_READ     8'h00
`define SRS_BANK_STRIDE_LOG2  3
`define SRS_NUM_REGS          26

`endif

// ### hw/srs_regfile.v
/*
  small register array for the special register space: one write port,
  one read port with registered read data.
  assumes the parent decodes addresses to an index and holds the enable.
*/
`timescale 1ns/10ps
module srs_regfile #(
   parameter DEPTH  = 26,
   parameter AW     = 5,
   parameter WIDTH  = 8
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             clk_en,
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_idx,
   input  wire [WIDTH-1:0] wr_data,
   input  wire [AW-1:0]    rd_idx,
   input  wire [DEPTH*WIDTH-1:0] rst_vals,
   output wire [DEPTH*WIDTH-1:0] all_q,
   output reg  [WIDTH-1:0] rd_data_ff
);

   reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
   wire [WIDTH-1:0] nxt_rd_data;

   assign nxt_rd_data = mem_ff[rd_idx];

   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1)
      begin : g_ent
         // reset values come from constants wired in by the parent
         always @(posedge clk)
         begin
            if (!rst_n)
               mem_ff[i] <= rst_vals[i*WIDTH +: WIDTH];
            else if (clk_en && wr_en && (wr_idx == i[AW-1:0]))
               mem_ff[i] <= wr_data;
         end
         assign all_q[i*WIDTH +: WIDTH] = mem_ff[i];
      end
   endgenerate

   always @(posedge clk)
   begin
      if (!rst_n)
         rd_data_ff <= {WIDTH{1'b0}};
      else if (clk_en)
         rd_data_ff <= nxt_rd_data;
   end

endmodule

// ### verification/srs_top_props.sv
/* checker for the special register space ports.
   assumes a bind onto srs_top and one clock domain. */
`timescale 1ns/10ps
module srs_top_props (
   input wire       clk,
   input wire       rst_n,
   input wire       clk_en,
   input wire [7:0] addr,
   input wire       wr_stb,
   input wire       rd_stb,
   input wire [7:0] rdata,
   input wire       ac_we,
   input wire       ac_in,
   input wire       cy_we,
   input wire       cy_in,
   input wire       aux_we,
   input wire [7:0] aux_in,
   input wire [7:0] acc_out,
   input wire [7:0] aux_out,
   input wire [7:0] status_out,
   input wire [4:0] bank_base
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire sw = wr_stb && clk_en && addr == 8'hd0;
   a_parity_acc: assert property (status_out[0] == ^acc_out)
      else $error("parity bit differs from accumulator");
   a_bank_base_map: assert property (bank_base == {status_out[4:3], 3'b000})
      else $error("bank base does not follow selector");
   a_rsvd_bit_zero: assert property (status_out[1] == 1'b0)
      else $error("reserved status bit set");
   a_unmapped_read: assert property (rd_stb && clk_en && addr == 8'hd8 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_user_flag_hold: assert property (!sw |=> $stable(status_out[5]))
      else $error("user flag moved without a write");
   a_half_carry_upd: assert property (ac_we && clk_en |=> status_out[6] == $past(ac_in))
      else $error("half carry not updated");
   a_carry_upd: assert property (cy_we && clk_en |=> status_out[7] == $past(cy_in))
      else $error("carry not updated");
   a_aux_hw_write: assert property (aux_we && clk_en |=> aux_out == $past(aux_in))
      else $error("aux register missed core write");
   a_frozen_state: assert property (!clk_en |=> $stable(status_out) && $stable(acc_out) && $stable(aux_out))
      else $error("state moved while clock enable low");
endmodule
bind srs_top srs_top_props u_props (.clk, .rst_n, .clk_en, .addr, .wr_stb, .rd_stb, .rdata, .ac_we, .ac_in,
   .cy_we, .cy_in, .aux_we, .aux_in, .acc_out, .aux_out, .status_out, .bank_base);

// ### verification/srs_top_tb_top.sv
/* self-checking bench for srs_top, one scenario task per behaviour.
   assumes the bound checker; a second instance lacks the third timer. */
`timescale 1ns/10ps
module srs_top_tb_top;
   reg        clk, rst_n, clk_en, wr_stb, rd_stb;
   reg        cy_we, cy_in, ac_we, ac_in, ov_we, ov_in, acc_we, aux_we;
   reg  [7:0] addr, wdata, acc_in, aux_in, q, q2;
   wire [7:0] rdata, rdata2, acc_out, aux_out, status_out, p0, p1, p2, p3;
   wire [4:0] bank_base;
   integer    num_errors = 0;
   integer    n_checks = 0;
   integer    i;
   reg  [7:0] mapped [0:23];
   reg  [7:0] holes [0:6];
   srs_top DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .cy_we(cy_we), .cy_in(cy_in), .ac_we(ac_we), .ac_in(ac_in),
      .ov_we(ov_we), .ov_in(ov_in), .acc_we(acc_we), .acc_in(acc_in), .aux_we(aux_we), .aux_in(aux_in),
      .acc_out(acc_out), .aux_out(aux_out), .status_out(status_out), .bank_base(bank_base),
      .port0_out(p0), .port1_out(p1), .port2_out(p2), .port3_out(p3));
   // same stimulus, variant without the third timer
   srs_top #(.HAS_TIMER2(0)) DUT2 (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata2), .cy_we(cy_we), .cy_in(cy_in), .ac_we(ac_we),
      .ac_in(ac_in), .ov_we(ov_we), .ov_in(ov_in), .acc_we(acc_we), .acc_in(acc_in), .aux_we(aux_we),
      .aux_in(aux_in), .acc_out(), .aux_out(), .status_out(), .bank_base(), .port0_out(), .port1_out(),
      .port2_out(), .port3_out());
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task chk(input [7:0] got, input [7:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk) begin addr <= a; wdata <= d; wr_stb <= 1'b1; end
      @(posedge clk) wr_stb <= 1'b0;
      @(negedge clk);
   end
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input [7:0] a);
   begin
      @(posedge clk) begin addr <= a; rd_stb <= 1'b1; end
      @(posedge clk) rd_stb <= 1'b0;
      @(negedge clk) begin q = rdata; q2 = rdata2; end
   end
   endtask
   task hw(input [2:0] we, input [2:0] v, input bus);
   begin
      @(posedge clk)
      begin
         {cy_we, ac_we, ov_we} <= we; {cy_in, ac_in, ov_in} <= v;
         addr <= 8'hd0; wdata <= 8'h00; wr_stb <= bus;
      end
      @(posedge clk) begin {cy_we, ac_we, ov_we} <= 3'b000; wr_stb <= 1'b0; end
      @(negedge clk);
   end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
   begin
      rd(8'h81); chk(q, 8'h07);
      rd(8'h80); chk(q, 8'hff);
      chk(p3, 8'hff);
      rd(8'hd0); chk(q, 8'h00);
      $display("test reset done");
   end
   endtask
   task t_map;
   begin
      for (i = 0; i < 24; i = i + 1)
      begin
         wr(mapped[i], ~mapped[i]); rd(mapped[i]);
         chk(q, ~mapped[i]);
         if (mapped[i] >= 8'hc8 && mapped[i] <= 8'hcd)
            chk(q2, 8'h00);
         else
            chk(q2, ~mapped[i]);
      end
      chk(p0, 8'h7f); chk(p1, 8'h6f); chk(p2, 8'h5f); chk(p3, 8'h4f);
      for (i = 0; i < 7; i = i + 1)
      begin
         wr(holes[i], 8'ha5); rd(holes[i]);
         chk(q, 8'h00);
      end
      $display("test map done");
   end
   endtask
   task t_status;
   begin
      wr(8'he0, 8'h07); wr(8'hd0, 8'hff); rd(8'hd0);
      chk(q, 8'hfd);
      chk({3'b000, bank_base}, 8'h18);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'hd0, i << 3);
         chk({3'b000, bank_base}, i * 8);
         chk(status_out, {3'b000, i[1:0], 3'b001});
      end
      wr(8'hd0, 8'h20);
      hw(3'b111, 3'b111, 1'b0);
      chk(status_out, 8'he5);
      hw(3'b110, 3'b100, 1'b1);
      chk(status_out, 8'h81);
      $display("test status done");
   end
   endtask
   // nothing may move while the clock enable is low
   task t_freeze;
   begin
      @(posedge clk) clk_en <= 1'b0;
      wr(8'h80, 8'h12);
      hw(3'b111, 3'b000, 1'b0);
      @(posedge clk) clk_en <= 1'b1;
      @(negedge clk);
      chk(p0, 8'h7f);
      chk(status_out, 8'h81);
      rd(8'h80);
      chk(q, 8'h7f);
      $display("test freeze done");
   end
   endtask
   task t_core;
   begin
      for (i = 0; i < 6; i = i + 1)
      begin
         @(posedge clk)
         begin
            acc_we <= 1'b1; aux_we <= 1'b1;
            acc_in <= holes[i] ^ i[7:0]; aux_in <= ~holes[i];
         end
         @(posedge clk) begin acc_we <= 1'b0; aux_we <= 1'b0; end
         @(negedge clk);
         chk({7'd0, status_out[0]}, {7'd0, ^(holes[i] ^ i[7:0])});
         chk(acc_out, holes[i] ^ i[7:0]);
         chk(aux_out, ~holes[i]);
      end
      rd(8'hf0);
      chk(q, ~holes[5]);
      rd(8'he0);
      chk(q, holes[5] ^ 8'h05);
      $display("test core done");
   end
   endtask
   task stop_test;
   begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #100000;
      num_errors = num_errors + 1;
      stop_test;
   end
   initial
   begin
      {rst_n, wr_stb, rd_stb, cy_we, cy_in, ac_we, ac_in, ov_we, ov_in, acc_we, aux_we} = 11'd0;
      clk_en = 1'b1; addr = 8'h00; wdata = 8'h00; acc_in = 8'h00; aux_in = 8'h00;
      mapped = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90,
                 8'h98, 8'h99, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hf0};
      holes = '{8'h84, 8'h85, 8'h8e, 8'hc0, 8'hd8, 8'hff, 8'hc9};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset; t_map; t_status; t_freeze; t_core;
      stop_test;
   end
endmodule
